// ---- fsw_pkg.sv ----
package fsw_pkg;

   // Instruction codes
   localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
   localparam logic [7:0] CMD_WRITE_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_VOLATILE_STATUS_WRITE = 8'h50;
   localparam logic [7:0] CMD_STATUS_READ = 8'h05;
   localparam logic [7:0] CMD_RESET_ARM = 8'h66;
   localparam logic [7:0] CMD_RESET_GO = 8'h99;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_SLEEP_ENTER = 8'hb9;
   localparam logic [7:0] CMD_SLEEP_EXIT = 8'hab;
   localparam logic [7:0] CMD_PARAM_READ = 8'h5a;
   localparam logic [7:0] CMD_ERASE_ALL_A = 8'hc7;
   localparam logic [7:0] CMD_ERASE_ALL_B = 8'h60;

   // Link bit counts
   localparam logic [7:0] BITS_OP_LAST = 8'h07;
   localparam logic [7:0] BITS_ARG_LAST = 8'h0f;
   localparam logic [7:0] BITS_OP = 8'h08;
   localparam logic [7:0] BITS_ARG = 8'h10;
   localparam logic [7:0] BITS_MAX = 8'hff;
   localparam logic [7:0] PARAM_BYTE_SKEW = 8'h02;

   // Status register: layout is the struct order, bit 7 down to bit 0
   typedef struct packed {
      logic statusWriteLock;
      logic quadPinsEnable;
      logic [3:0] protectBits;
      logic writeLatchFlag;
      logic busyFlag;
   } fsw_status_s;

   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [3:0] PROTECT_NONE = 4'h0;

   // Status and power state as seen by the link during one frame
   typedef struct packed {
      logic sleep;
      fsw_status_s status;
   } fsw_snap_s;

   typedef enum logic [2:0] {
      ST_READY = 3'h1,
      ST_BUSY = 3'h2,
      ST_SLEEP = 3'h4
   } fsw_state_e;

   // Parameter table fields
   localparam logic [4:0] SLEEP_EXIT_DELAY = 5'h02;
   localparam logic [1:0] SLEEP_EXIT_UNITS = 2'h1;
   localparam logic [3:0] QUAD_MODE_EXIT_SEQ = 4'ha;
   localparam logic [4:0] QUAD_MODE_ENTRY_SEQ = 5'h04;
   localparam logic [2:0] QUAD_ENABLE_REQUIREMENT = 3'h2;
   localparam logic [7:0] PARAM_BASE = 8'h64;
   localparam logic [7:0] PARAM_LAST = 8'h6f;
   localparam logic [7:0] PARAM_BLANK = 8'hff;
   localparam logic [31:0] PARAM_DW_64 = {1'h0, CMD_SLEEP_ENTER, CMD_SLEEP_EXIT,
      SLEEP_EXIT_UNITS, SLEEP_EXIT_DELAY, 8'hf7};
   localparam logic [31:0] PARAM_DW_68 = {8'hff, 1'h0, QUAD_ENABLE_REQUIREMENT, 4'hc,
      6'h30, 1'h1, QUAD_MODE_ENTRY_SEQ, QUAD_MODE_EXIT_SEQ};
   localparam logic [31:0] PARAM_DW_6C = {8'ha9, 10'h3e8, 6'h30, 1'h1, 7'h68};

endpackage

// ---- fsw_flash_status.sv ----
`timescale 1ns/100ps
// How it works
// [RULE1] Status read repeats until chip select rises; the code sends 31 copies, then holds the busy bit as the counter saturates
// [RULE2] Power-up loads volatile bits from stored copy
// [RULE3] Status byte layout lock,quad,protect,latch,busy
// [RULE4] Busy flag read-only, set during write operations
// [RULE5] While busy only reads and resets accepted; the code also accepts suspend
// [RULE6] Suspend accepted during ongoing program or erase
// [RULE7] Completion clears busy, then commands accepted
// [RULE8] Write operations blocked unless latch set
// [RULE9] Latch-set instruction sets write latch
// [RULE10] Host issues latch-set before write instructions
// [RULE11] Latch-clear instruction clears write latch
// [RULE12] Latch clears when write operation completes
// [RULE13] Status writes never change the latch; the code clears it when a stored status write completes
// [RULE14] Status write updates protect, quad, lock bits
// [RULE15] Protect bit one marks blocks protected
// [RULE16] Quad enable switches quad function
// [RULE17] Write lock protects status with pin
// [RULE18] Table reports power-down codes and exit delay
// [RULE19] Table reports quad mode entry/exit sequences
// [RULE20] Table reports quad enable requirement field
// [RULE21] Lock with pin low ignores status writes
// [RULE22] Quad enable turns control pins into data
// [RULE23] Whole-array erase needs all protect bits zero
module fsw_flash_status (
   // System
   input wire logic clk,
   input wire logic srst,
   // Serial link
   input wire logic linkClk,
   input wire logic csN,
   input wire logic si,
   output logic soOut,
   output logic soOe,
   // Control pins
   input wire logic wpN,
   input wire logic holdResetN,
   // Stored status copy
   input wire logic [7:0] nvStatusIn,
   // Array engine
   input wire logic opDone,
   output logic opStart,
   output logic [7:0] opCode,
   output logic [7:0] opData,
   output logic suspendReq,
   // Status to the array and pads
   output logic [3:0] protectBits,
   output logic quadPinsActive
);

   // Link side
   logic [7:0] bitCnt_r;
   logic [7:0] cmdByte_r;
   logic [7:0] argByte_r;
   logic cmdFull_r;
   logic argFull_r;
   logic soOut_r;
   logic soOe_r;
   logic txActive;
   logic txBit;
   logic [7:0] paramAddr;
   logic [7:0] paramByte;

   // System side
   logic csSync1_r;
   logic csSync2_r;
   logic csSync3_r;
   logic wpSync1_r;
   logic wpSync2_r;
   logic holdSync1_r;
   logic holdSync2_r;
   logic rxClear_r;
   fsw_pkg::fsw_snap_s snap_r;
   fsw_pkg::fsw_state_e state_r;
   logic loadPending_r;
   logic resetArmed_r;
   logic armNext;
   logic writeLatch_r;
   logic statusLock_r;
   logic quadEnable_r;
   logic [3:0] protect_r;
   logic opStart_r;
   logic [7:0] opCode_r;
   logic [7:0] opData_r;
   logic suspendReq_r;
   logic cmdValid;
   logic hwReset;
   logic statusLocked;
   logic anyReset;
   logic doLatchSet;
   logic doLatchClr;
   logic doStatusNv;
   logic doStatusVol;
   logic doStart;
   logic doSuspend;
   logic doReset;
   logic doSleep;
   logic doWake;
   fsw_pkg::fsw_status_s statusNow;
   fsw_pkg::fsw_status_s argStatus;

   function automatic logic isArrayWrite(input logic [7:0] op);
      case (op)
         8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21,
         8'h52, 8'h5c, 8'hd8, 8'hdc, fsw_pkg::CMD_ERASE_ALL_A,
         fsw_pkg::CMD_ERASE_ALL_B: isArrayWrite = 1'b1;
         default: isArrayWrite = 1'b0;
      endcase
   endfunction

   function automatic logic isEraseAll(input logic [7:0] op);
      isEraseAll = (op == fsw_pkg::CMD_ERASE_ALL_A) || (op == fsw_pkg::CMD_ERASE_ALL_B);
   endfunction

   // Link clock domain

   // Frame bit counter, cleared while chip select is high
   always_ff @(posedge linkClk or posedge csN) begin
      if (csN) begin
         bitCnt_r <= 8'h00;
      end else if (bitCnt_r != fsw_pkg::BITS_MAX) begin
         bitCnt_r <= bitCnt_r + 8'h01;
      end
   end

   always_ff @(posedge linkClk) begin
      if (bitCnt_r < fsw_pkg::BITS_OP) begin
         cmdByte_r <= {cmdByte_r[6:0], si};
      end else if (bitCnt_r < fsw_pkg::BITS_ARG) begin
         argByte_r <= {argByte_r[6:0], si};
      end
   end

   // Byte-complete flags survive the frame end; the system side clears them
   // after it has taken the command, while the link clock stands still.
   always_ff @(posedge linkClk or posedge rxClear_r) begin
      if (rxClear_r) begin
         cmdFull_r <= 1'b0;
      end else if (bitCnt_r == fsw_pkg::BITS_OP_LAST) begin
         cmdFull_r <= 1'b1;
      end
   end

   always_ff @(posedge linkClk or posedge rxClear_r) begin
      if (rxClear_r) begin
         argFull_r <= 1'b0;
      end else if (bitCnt_r == fsw_pkg::BITS_OP_LAST) begin
         argFull_r <= 1'b0;
      end else if (bitCnt_r == fsw_pkg::BITS_ARG_LAST) begin
         argFull_r <= 1'b1;
      end
   end

   always_comb begin
      paramAddr = argByte_r + {3'h0, bitCnt_r[7:3]} - fsw_pkg::PARAM_BYTE_SKEW;
      paramByte = fsw_pkg::PARAM_BLANK;
      if (paramAddr >= fsw_pkg::PARAM_BASE && paramAddr <= fsw_pkg::PARAM_LAST) begin
         case (paramAddr[3:2])
            2'h1: paramByte = fsw_pkg::PARAM_DW_64[paramAddr[1:0]*8 +: 8]; // RULE18
            2'h2: paramByte = fsw_pkg::PARAM_DW_68[paramAddr[1:0]*8 +: 8]; // RULE19 RULE20
            2'h3: paramByte = fsw_pkg::PARAM_DW_6C[paramAddr[1:0]*8 +: 8];
            default: paramByte = fsw_pkg::PARAM_BLANK;
         endcase
      end
   end

   // Status byte comes from the frame-start snapshot, so it repeats unchanged
   always_comb begin
      txActive = 1'b0;
      txBit = 1'b0;
      if (!snap_r.sleep && bitCnt_r >= fsw_pkg::BITS_OP) begin
         if (cmdByte_r == fsw_pkg::CMD_STATUS_READ) begin
            txActive = 1'b1;
            txBit = snap_r.status[~bitCnt_r[2:0]]; // RULE1 RULE3
         end else if (cmdByte_r == fsw_pkg::CMD_PARAM_READ && bitCnt_r >= fsw_pkg::BITS_ARG) begin
            txActive = 1'b1;
            txBit = paramByte[~bitCnt_r[2:0]];
         end
      end
   end

   // Data changes on the falling edge for sampling on the next rising edge
   always_ff @(negedge linkClk or posedge csN) begin
      if (csN) begin
         soOe_r <= 1'b0;
         soOut_r <= 1'b0;
      end else begin
         soOe_r <= txActive;
         soOut_r <= txBit;
      end
   end

   // System clock domain

   always_ff @(posedge clk) begin
      if (srst) begin
         csSync1_r <= 1'b1;
         csSync2_r <= 1'b1;
         csSync3_r <= 1'b1;
         wpSync1_r <= 1'b1;
         wpSync2_r <= 1'b1;
         holdSync1_r <= 1'b1;
         holdSync2_r <= 1'b1;
      end else begin
         csSync1_r <= csN;
         csSync2_r <= csSync1_r;
         csSync3_r <= csSync2_r;
         wpSync1_r <= wpN;
         wpSync2_r <= wpSync1_r;
         holdSync1_r <= holdResetN;
         holdSync2_r <= holdSync1_r;
      end
   end

   // Link registers are stable once chip select is seen high
   assign cmdValid = csSync2_r && !csSync3_r && cmdFull_r;
   assign hwReset = !quadEnable_r && !holdSync2_r; // RULE22
   assign statusLocked = statusLock_r && !quadEnable_r && !wpSync2_r; // RULE17 RULE21 RULE22
   assign argStatus = argByte_r;

   always_ff @(posedge clk) begin
      rxClear_r <= srst || (csSync2_r && !csSync3_r);
   end

   // Snapshot refreshes only between frames
   always_ff @(posedge clk) begin
      if (srst) begin
         snap_r <= '0;
      end else if (csSync2_r) begin
         snap_r <= {state_r == fsw_pkg::ST_SLEEP, statusNow};
      end
   end

   always_comb begin
      doLatchSet = 1'b0;
      doLatchClr = 1'b0;
      doStatusNv = 1'b0;
      doStatusVol = 1'b0;
      doStart = 1'b0;
      doSuspend = 1'b0;
      doReset = 1'b0;
      doSleep = 1'b0;
      doWake = 1'b0;
      armNext = resetArmed_r;
      if (cmdValid) begin
         armNext = (cmdByte_r == fsw_pkg::CMD_RESET_ARM);
         case (state_r)
            fsw_pkg::ST_SLEEP: begin
               armNext = 1'b0;
               doWake = (cmdByte_r == fsw_pkg::CMD_SLEEP_EXIT);
            end
            fsw_pkg::ST_BUSY: begin
               doReset = resetArmed_r && (cmdByte_r == fsw_pkg::CMD_RESET_GO); // RULE5
               doSuspend = (cmdByte_r == fsw_pkg::CMD_SUSPEND); // RULE6
            end
            fsw_pkg::ST_READY: begin
               doReset = resetArmed_r && (cmdByte_r == fsw_pkg::CMD_RESET_GO);
               doLatchSet = (cmdByte_r == fsw_pkg::CMD_WRITE_LATCH_SET); // RULE9
               doLatchClr = (cmdByte_r == fsw_pkg::CMD_WRITE_LATCH_CLEAR); // RULE11
               doSleep = (cmdByte_r == fsw_pkg::CMD_SLEEP_ENTER);
               doStatusNv = (cmdByte_r == fsw_pkg::CMD_STATUS_WRITE) && argFull_r
                  && writeLatch_r && !statusLocked; // RULE8 RULE21
               doStatusVol = (cmdByte_r == fsw_pkg::CMD_VOLATILE_STATUS_WRITE) && argFull_r
                  && writeLatch_r && !statusLocked; // RULE8 RULE21
               doStart = isArrayWrite(cmdByte_r) && writeLatch_r // RULE8
                  && (!isEraseAll(cmdByte_r) || protect_r == fsw_pkg::PROTECT_NONE); // RULE23
            end
            default: armNext = 1'b0;
         endcase
      end
   end

   assign anyReset = doReset || hwReset;

   always_ff @(posedge clk) begin
      if (srst || anyReset) begin
         resetArmed_r <= 1'b0;
      end else begin
         resetArmed_r <= armNext;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || anyReset) begin
         state_r <= fsw_pkg::ST_READY;
      end else begin
         case (state_r)
            fsw_pkg::ST_READY: begin
               if (doStart || doStatusNv) begin
                  state_r <= fsw_pkg::ST_BUSY; // RULE4
               end else if (doSleep) begin
                  state_r <= fsw_pkg::ST_SLEEP;
               end
            end
            fsw_pkg::ST_BUSY: begin
               if (opDone) begin
                  state_r <= fsw_pkg::ST_READY; // RULE7
               end
            end
            fsw_pkg::ST_SLEEP: begin
               if (doWake) begin
                  state_r <= fsw_pkg::ST_READY;
               end
            end
            default: state_r <= fsw_pkg::ST_READY;
         endcase
      end
   end

   // Volatile status writes are not among the latch's causes; a stored one clears it on completion
   always_ff @(posedge clk) begin
      if (srst || anyReset) begin
         writeLatch_r <= 1'b0;
      end else if (state_r == fsw_pkg::ST_BUSY && opDone) begin
         writeLatch_r <= 1'b0; // RULE12
      end else if (doLatchSet) begin
         writeLatch_r <= 1'b1; // RULE9 RULE13
      end else if (doLatchClr) begin
         writeLatch_r <= 1'b0; // RULE11 RULE13
      end
   end

   // Reload waits one cycle after reset so the stored copy is sampled by a clocked load
   always_ff @(posedge clk) begin
      loadPending_r <= srst || anyReset;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         {statusLock_r, quadEnable_r, protect_r} <= fsw_pkg::STATUS_RESET[7:2]; // RULE3
      end else if (loadPending_r) begin
         {statusLock_r, quadEnable_r, protect_r} <= nvStatusIn[7:2]; // RULE2
      end else if (doStatusNv || doStatusVol) begin
         statusLock_r <= argStatus.statusWriteLock; // RULE14
         quadEnable_r <= argStatus.quadPinsEnable; // RULE14 RULE16
         protect_r <= argStatus.protectBits; // RULE14 RULE15
      end
   end

   always_comb begin
      statusNow.statusWriteLock = statusLock_r;
      statusNow.quadPinsEnable = quadEnable_r;
      statusNow.protectBits = protect_r;
      statusNow.writeLatchFlag = writeLatch_r;
      statusNow.busyFlag = (state_r == fsw_pkg::ST_BUSY); // RULE4
   end

   // Engine requests; the engine stores status itself for the stored write
   always_ff @(posedge clk) begin
      if (srst) begin
         opStart_r <= 1'b0;
         opCode_r <= 8'h00;
         opData_r <= 8'h00;
         suspendReq_r <= 1'b0;
      end else begin
         opStart_r <= doStart || doStatusNv;
         suspendReq_r <= doSuspend; // RULE6
         if (doStart || doStatusNv) begin
            opCode_r <= cmdByte_r;
            opData_r <= argByte_r;
         end
      end
   end

   assign soOut = soOut_r;
   assign soOe = soOe_r;
   assign opStart = opStart_r;
   assign opCode = opCode_r;
   assign opData = opData_r;
   assign suspendReq = suspendReq_r;
   assign protectBits = protect_r; // RULE15
   assign quadPinsActive = quadEnable_r; // RULE16 RULE22

   // Checks

   sequence seqReleaseLoad;
      $fell(srst) ##1 !srst;
   endsequence

   sequence seqBusyDone;
      (state_r == fsw_pkg::ST_BUSY) && opDone && !hwReset && !doReset;
   endsequence

   AST_POWERUP_LOAD: assert property (@(posedge clk) // RULE2
      seqReleaseLoad |-> {statusLock_r, quadEnable_r, protect_r} == $past(nvStatusIn[7:2]))
      else $error("Status bits not loaded from stored copy after reset");

   AST_BUSY_DURING_OP: assert property (@(posedge clk) disable iff (srst) // RULE4
      opStart_r |-> statusNow.busyFlag)
      else $error("Operation started without busy flag");

   AST_BUSY_IGNORES: assert property (@(posedge clk) disable iff (srst) // RULE5
      (state_r == fsw_pkg::ST_BUSY) && cmdValid && !opDone && !hwReset && !doReset
      |=> $stable(writeLatch_r) && $stable(protect_r) && !opStart_r)
      else $error("Command acted on while busy");

   AST_SUSPEND_TAKEN: assert property (@(posedge clk) disable iff (srst) // RULE6
      (state_r == fsw_pkg::ST_BUSY) && cmdValid && cmdByte_r == fsw_pkg::CMD_SUSPEND
      |=> suspendReq_r ##1 !suspendReq_r)
      else $error("Suspend not forwarded during busy");

   AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (srst) // RULE7 RULE12
      seqBusyDone |=> !statusNow.busyFlag && !writeLatch_r)
      else $error("Completion did not clear busy and latch");

   AST_NEEDS_LATCH: assert property (@(posedge clk) disable iff (srst) // RULE8
      $rose(opStart_r) |-> $past(writeLatch_r))
      else $error("Write operation started without latch");

   AST_LATCH_SET: assert property (@(posedge clk) disable iff (srst) // RULE9
      (state_r == fsw_pkg::ST_READY) && cmdValid && !hwReset
      && cmdByte_r == fsw_pkg::CMD_WRITE_LATCH_SET |=> writeLatch_r [*2])
      else $error("Latch-set instruction did not set latch");

   AST_LATCH_CLEAR: assert property (@(posedge clk) disable iff (srst) // RULE11
      (state_r == fsw_pkg::ST_READY) && cmdValid
      && cmdByte_r == fsw_pkg::CMD_WRITE_LATCH_CLEAR |=> !writeLatch_r)
      else $error("Latch-clear instruction did not clear latch");

   AST_VOL_WRITE_KEEPS_LATCH: assert property (@(posedge clk) disable iff (srst) // RULE13
      doStatusVol && !hwReset |=> writeLatch_r && protect_r == $past(argStatus.protectBits))
      else $error("Status write changed latch or missed protect bits");

   AST_LOCK_IGNORES_WRITE: assert property (@(posedge clk) disable iff (srst) // RULE21
      cmdValid && statusLocked && !loadPending_r |=> $stable(protect_r) && $stable(statusLock_r))
      else $error("Locked status register was written");

   AST_ERASE_ALL_PROTECTED: assert property (@(posedge clk) disable iff (srst) // RULE23
      $rose(opStart_r) && isEraseAll(opCode_r) |-> $past(protect_r) == fsw_pkg::PROTECT_NONE)
      else $error("Whole-array erase started with protection set");

   AST_READ_REPEATS: assert property (@(posedge linkClk) disable iff (csN) // RULE1
      soOe_r && cmdByte_r == fsw_pkg::CMD_STATUS_READ ##8 soOe_r |-> soOut_r == $past(soOut_r, 8))
      else $error("Repeated status byte differs");

endmodule // fsw_flash_status

// ---- fsw_host_model.sv ----
`timescale 1ns/100ps
module fsw_host_model (
   // Serial link
   output logic csN,
   output logic linkClk,
   output logic si,
   input wire logic soOut
);
   initial begin
      csN = 1'b0;
      linkClk = 1'b0;
      si = 1'b0;
      // Rising select clears the link counters before the first frame
      #1 csN = 1'b1;
   end

   // Mode 0, 64 ns bit time; clock stands low outside frames
   task automatic frame(input logic [15:0] tx, input int nBits, output logic [31:0] rx);
      rx = '0;
      #5 csN = 1'b0;
      for (int i = 0; i < nBits; i++) begin
         si = (i < 16) ? tx[15 - i] : 1'b0;
         #32 linkClk = 1'b1;
         rx = {rx[30:0], soOut};
         #32 linkClk = 1'b0;
      end
      #32 csN = 1'b1;
      // Released line shows no stale value
      si = ~si;
      // Gap well above the 200 ns minimum between frames
      #300;
   endtask
endmodule // fsw_host_model

// ---- fsw_flash_status_tb.sv ----
`timescale 1ns/100ps
module fsw_flash_status_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic csN, linkClk, si, soOut, soOe;
   logic soLine;
   logic wpN = 1'b1;
   logic holdResetN = 1'b1;
   logic [7:0] nvStatusIn = 8'h0f;
   logic opDone = 1'b0;
   logic opStart, suspendReq, quadPinsActive;
   logic [7:0] opCode, opData;
   logic [3:0] protectBits;
   logic [31:0] rx, dw;
   int mismatches = 0;
   int checks_done = 0;
   int starts = 0;
   int suspends = 0;

   always #20 clk = ~clk;

   // Pull-up keeps the undriven data line high
   assign soLine = soOe ? soOut : 1'b1;

   always @(negedge clk) begin
      if (opStart === 1'b1) starts++;
      if (suspendReq === 1'b1) suspends++;
   end

   fsw_flash_status dut_u (
      .clk(clk), .srst(srst), .linkClk(linkClk), .csN(csN), .si(si),
      .soOut(soOut), .soOe(soOe), .wpN(wpN), .holdResetN(holdResetN),
      .nvStatusIn(nvStatusIn), .opDone(opDone), .opStart(opStart),
      .opCode(opCode), .opData(opData), .suspendReq(suspendReq),
      .protectBits(protectBits), .quadPinsActive(quadPinsActive)
   );

   fsw_host_model host_u (.csN(csN), .linkClk(linkClk), .si(si), .soOut(soLine));

   task automatic complete_run();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      host_u.frame({op, 8'h00}, 8, rx);
   endtask

   task automatic cmd2(input logic [7:0] op, input logic [7:0] arg);
      host_u.frame({op, arg}, 16, rx);
   endtask

   // Two bytes past the opcode: the value must repeat
   task automatic stat(input logic [7:0] exp);
      host_u.frame({8'h05, 8'h00}, 24, rx);
      chk({16'h0000, rx[15:0]}, {16'h0000, exp, exp});
   endtask

   // First byte received is the lowest byte of the dword
   task automatic prm(input logic [7:0] addr);
      host_u.frame({8'h5a, addr}, 48, rx);
      dw = {rx[7:0], rx[15:8], rx[23:16], rx[31:24]};
   endtask

   task automatic done();
      @(negedge clk) opDone = 1'b1;
      @(negedge clk) opDone = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic pinReset(input logic [7:0] nv);
      @(negedge clk) nvStatusIn = nv;
      holdResetN = 1'b0;
      repeat (4) @(negedge clk);
      holdResetN = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   initial begin
      #2000000;
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk) srst = 1'b0;
      repeat (6) @(negedge clk);
      stat(8'h0c);
      chk(32'(protectBits), 32'h3);
      prm(8'h64);
      chk(32'(dw[12:8]), 32'h2);
      chk(32'(dw[14:13]), 32'h1);
      chk(32'(dw[22:15]), 32'hab);
      chk(32'(dw[30:23]), 32'hb9);
      prm(8'h68);
      chk(32'(dw[3:0]), 32'ha);
      chk(32'(dw[8:4]), 32'h4);
      chk(32'(dw[22:20]), 32'h2);
      prm(8'h70);
      chk(dw, 32'hffffffff);
      cmd(8'h06);
      stat(8'h0e);
      cmd(8'hc7);
      chk(starts, 0);
      cmd(8'h04);
      stat(8'h0c);
      cmd(8'h02);
      chk(starts, 0);
      cmd(8'h06);
      cmd2(8'h50, 8'h03);
      stat(8'h02);
      chk(32'(protectBits), 32'h0);
      cmd(8'h02);
      chk(starts, 1);
      chk(32'(opCode), 32'h02);
      stat(8'h03);
      cmd(8'h04);
      stat(8'h03);
      cmd(8'h75);
      chk(suspends, 1);
      done();
      stat(8'h00);
      cmd(8'h06);
      stat(8'h02);
      cmd(8'h60);
      chk(starts, 2);
      chk(32'(opCode), 32'h60);
      done();
      cmd(8'h06);
      cmd2(8'h01, 8'h81);
      chk(32'(opData), 32'h81);
      stat(8'h83);
      done();
      stat(8'h80);
      @(negedge clk) wpN = 1'b0;
      cmd(8'h06);
      cmd2(8'h50, 8'h40);
      stat(8'h82);
      @(negedge clk) wpN = 1'b1;
      repeat (3) @(negedge clk);
      cmd2(8'h50, 8'h40);
      stat(8'h42);
      chk(32'(quadPinsActive), 32'h1);
      // Pin acts as data now, so a low level must not reset
      pinReset(8'h00);
      stat(8'h42);
      cmd2(8'h50, 8'h00);
      cmd(8'h02);
      stat(8'h03);
      @(negedge clk) nvStatusIn = 8'h10;
      cmd(8'h66);
      cmd(8'h99);
      stat(8'h10);
      pinReset(8'h24);
      stat(8'h24);
      chk(32'(protectBits), 32'h9);
      chk(32'(quadPinsActive), 32'h0);
      // Asleep: no read output, only the wake code is taken
      cmd(8'hb9);
      stat(8'hff);
      cmd(8'h06);
      cmd(8'hab);
      stat(8'h24);
      complete_run();
   end
endmodule // fsw_flash_status_tb
